// ===== rtl/srfc_host.v
// Host controller: frames a request, sends it over a byte UART, and
// checks the device's reply in ASCII or RTU mode.
// Assumes a byte UART (tx ready/valid, rx strobe) on the same clock;
// the caller presents request bytes one at a time on req_* ports.
`timescale 1ns/1ps
`include "srfc_defs.vh"
module srfc_host #(
  parameter [31:0] SIL = `SRFC_SIL_CYC, // Line silence in cycles
  parameter [31:0] TMO = `SRFC_TMO_CYC, // Reply wait in cycles
  parameter [31:0] GAP = `SRFC_GAP_CYC  // Hold-off between requests
) (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       ascii_mode_i,
  input  wire       start_i,
  input  wire [7:0] req_len_i,
  input  wire [7:0] req_byte_i,
  output reg  [7:0] req_idx_o,
  input  wire       tx_ready_i,
  output reg        tx_valid_o,
  output reg  [7:0] tx_byte_o,
  input  wire       rx_strobe_i,
  input  wire [7:0] rx_byte_i,
  output reg        busy_o,
  output reg        rsp_valid_o,
  output reg  [7:0] rsp_byte_o,
  output reg        done_o,
  output reg        ok_o,
  output reg        timeout_o
);
  localparam ST_IDLE = 3'd0, ST_GAP = 3'd1, ST_SEND = 3'd2, ST_TAIL = 3'd3,
             ST_WAIT = 3'd4, ST_SPACE = 3'd5;
  // State walk: IDLE takes start, GAP opens the frame (colon or line
  // silence), SEND streams the caller's bytes, TAIL adds check (and CR LF in ASCII) as end
  // delimiter, WAIT collects the reply, SPACE holds off the next request.
  // The same checksum unit serves transmit and receive; it is cleared at
  // the end of TAIL, so the reply never sees the request's running sum.
  // Limitation: ascii_mode_i is read live, so it must not change while
  // busy_o is high, or the frame mixes both encodings.
  // Silence, reply wait and gap are parameters so that a bench can run
  // them short; the defaults are the line's real figures.
  // A reply that never ends its line is cut off by the reply wait.
  reg  [2:0]  state;
  reg  [31:0] tmr;
  reg  [31:0] sil;
  reg  [7:0]  rcv_cnt;
  reg  [2:0]  tail;
  reg         hi_half;
  reg  [3:0]  nib;
  reg         rx_s1, rx_s2, rx_prev;
  reg  [7:0]  rx_d1, rx_d2;
  reg  [7:0]  rb0, rb1, rb2;
  reg         in_frame;
  reg         c_clr, c_step;
  reg  [7:0]  c_byte;
  wire [15:0] crc;
  wire [7:0]  lrc;
  wire        rx_evt = rx_s2 & ~rx_prev;
  //////////////////////////////////////////////////////////////////////
  // Nibble to hex character and back
  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
    end
  endfunction
  function [3:0] hexv;
    input [7:0] c;
    begin
      hexv = (c >= 8'h41) ? (c[3:0] + 4'h9) : c[3:0];
    end
  endfunction
  //////////////////////////////////////////////////////////////////////
  // Checksum unit, shared by transmit and receive
  srfc_crc_lrc u_chk (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .clr_i      (c_clr),
    .step_i     (c_step),
    .byte_i     (c_byte),
    .crc_o      (crc),
    .lrc_o      (lrc)
  );
  //////////////////////////////////////////////////////////////////////
  // Receive strobe and byte come from the UART clock edge; two stages
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_s1   <= 1'b0;
      rx_s2   <= 1'b0;
      rx_prev <= 1'b0;
      rx_d1   <= 8'h00;
      rx_d2   <= 8'h00;
    end else begin
      rx_s1   <= rx_strobe_i;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
      rx_d1   <= rx_byte_i;
      rx_d2   <= rx_d1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE; tmr <= 32'h0; sil <= 32'h0; tail <= 3'd0;
      hi_half <= 1'b1; nib <= 4'h0; rcv_cnt <= 8'h00; in_frame <= 1'b0;
      rb0 <= 8'h00; rb1 <= 8'h00; rb2 <= 8'h00;
      req_idx_o <= 8'h00; tx_valid_o <= 1'b0; tx_byte_o <= 8'h00;
      busy_o <= 1'b0; rsp_valid_o <= 1'b0; rsp_byte_o <= 8'h00;
      done_o <= 1'b0; ok_o <= 1'b0; timeout_o <= 1'b0;
      c_clr <= 1'b0; c_step <= 1'b0; c_byte <= 8'h00;
    end else begin
      c_clr <= 1'b0; c_step <= 1'b0;
      rsp_valid_o <= 1'b0; done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          busy_o <= 1'b0;
          if (start_i) begin
            busy_o <= 1'b1; c_clr <= 1'b1; req_idx_o <= 8'h00;
            tmr <= 32'h0; hi_half <= 1'b1; tail <= 3'd0;
            state <= ST_GAP;
          end
        end
        // Silence before frame in RTU; colon first in ASCII
        ST_GAP: begin
          tmr <= tmr + 32'h1;
          if (ascii_mode_i && tx_ready_i) begin
            tx_valid_o <= 1'b1; tx_byte_o <= `SRFC_CH_COLON;
            state <= ST_SEND;
          end else if (!ascii_mode_i && tmr >= SIL) begin
            state <= ST_SEND;
          end
        end
        // Address, function and data bytes as the caller supplies them
        ST_SEND: begin
          if (tx_valid_o && !tx_ready_i) begin
            tx_valid_o <= 1'b1;
          end else if (req_idx_o == req_len_i) begin
            tx_valid_o <= 1'b0; state <= ST_TAIL;
          end else if (ascii_mode_i) begin
            tx_valid_o <= 1'b1;
            tx_byte_o <= hexc(hi_half ? req_byte_i[7:4]
                                      : req_byte_i[3:0]);
            hi_half <= ~hi_half;
            if (!hi_half) begin
              req_idx_o <= req_idx_o + 8'h01;
              c_step <= 1'b1; c_byte <= req_byte_i;
            end
          end else begin
            tx_valid_o <= 1'b1; tx_byte_o <= req_byte_i;
            req_idx_o <= req_idx_o + 8'h01;
            c_step <= 1'b1; c_byte <= req_byte_i;
          end
        end
        // Check field, then the CR LF end delimiter in ASCII only
        ST_TAIL: begin
          if (tx_valid_o && !tx_ready_i) begin
            tx_valid_o <= 1'b1;
          end else if (ascii_mode_i && tail < 3'd4) begin
            tx_valid_o <= 1'b1; tail <= tail + 3'd1;
            case (tail)
              3'd0: tx_byte_o <= hexc(lrc[7:4]);
              3'd1: tx_byte_o <= hexc(lrc[3:0]);
              3'd2: tx_byte_o <= `SRFC_CH_CR;
              default: tx_byte_o <= `SRFC_CH_LF;
            endcase
          end else if (!ascii_mode_i && tail < 3'd2) begin
            tx_valid_o <= 1'b1; tail <= tail + 3'd1;
            tx_byte_o <= (tail == 3'd0) ? crc[7:0] : crc[15:8];
          end else begin
            tx_valid_o <= 1'b0; tmr <= 32'h0; sil <= 32'h0;
            c_clr <= 1'b1; rcv_cnt <= 8'h00; in_frame <= 1'b0;
            hi_half <= 1'b1; state <= ST_WAIT;
          end
        end
        // Collect the reply; give up after the reply timeout
        ST_WAIT: begin
          tmr <= tmr + 32'h1;
          sil <= rx_evt ? 32'h0 : sil + 32'h1;
          if (rx_evt) begin
            in_frame <= 1'b1;
            rb0 <= rx_d2; rb1 <= rb0; rb2 <= rb1;
            if (ascii_mode_i && rx_d2 == `SRFC_CH_COLON) begin
              c_clr <= 1'b1; rcv_cnt <= 8'h00; hi_half <= 1'b1;
            end else if (ascii_mode_i && rx_d2 == `SRFC_CH_LF) begin
              // Sum so far includes the LRC byte: a good frame sums to 0
              done_o <= 1'b1; ok_o <= (lrc == 8'h00) && rb0 == `SRFC_CH_CR;
              timeout_o <= 1'b0; tmr <= 32'h0; state <= ST_SPACE;
            end else if (ascii_mode_i && rx_d2 != `SRFC_CH_CR) begin
              hi_half <= ~hi_half;
              if (hi_half) begin
                nib <= hexv(rx_d2);
              end else begin
                c_step <= 1'b1; c_byte <= {nib, hexv(rx_d2)};
                rsp_valid_o <= 1'b1; rsp_byte_o <= {nib, hexv(rx_d2)};
                rcv_cnt <= rcv_cnt + 8'h01;
              end
            end else if (!ascii_mode_i) begin
              c_step <= 1'b1; c_byte <= rx_d2;
              rsp_valid_o <= 1'b1; rsp_byte_o <= rx_d2;
              rcv_cnt <= rcv_cnt + 8'h01;
            end
          end else if (!ascii_mode_i && in_frame && sil >= SIL) begin
            // Running CRC over data plus its own check leaves zero
            done_o <= 1'b1; ok_o <= (crc == 16'h0000) && rcv_cnt > 8'h03;
            timeout_o <= 1'b0; tmr <= 32'h0; state <= ST_SPACE;
          end else if (tmr >= TMO) begin
            done_o <= 1'b1; ok_o <= 1'b0; timeout_o <= 1'b1;
            tmr <= 32'h0; state <= ST_SPACE;
          end
        end
        // Minimum gap before the next request
        ST_SPACE: begin
          tmr <= tmr + 32'h1;
          if (tmr >= GAP) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // srfc_host

// ===== rtl/srfc_defs.vh
// Constants for the host-side serial register frame controller.
// Assumes a byte-wide UART outside this block and one 100 MHz clock.
`ifndef SRFC_DEFS_VH
`define SRFC_DEFS_VH
`define SRFC_CH_COLON    8'h3a
`define SRFC_CH_CR       8'h0d
`define SRFC_CH_LF       8'h0a
`define SRFC_FN_READ     8'h04
`define SRFC_FN_WRITE    8'h10
`define SRFC_CRC_INIT    16'hffff
`define SRFC_CRC_POLY    16'ha001
`define SRFC_ADDR_DEF    8'h01
`define SRFC_ADDR_MAX    8'h20
`define SRFC_CLK_HZ      100000000
`define SRFC_BAUD        19200
// One character is 11 bit times; silence is 3.5 characters = 38.5 bits
`define SRFC_SIL_BITS_X2 77
`define SRFC_BIT_CYC     (`SRFC_CLK_HZ / `SRFC_BAUD)
`define SRFC_SIL_CYC     ((`SRFC_BIT_CYC * `SRFC_SIL_BITS_X2 + 1) / 2)
// Reply wait and inter-request gap counts (1 s and 100 ms)
`define SRFC_TMO_CYC     100000000
`define SRFC_GAP_CYC     10000000
`define SRFC_MAX_RX      8'hff
`endif

// ===== rtl/srfc_crc_lrc.v
// Byte checksum unit: running CRC-16 and LRC sum over one frame.
// Assumes the caller pulses clr before each frame and step per byte.
`timescale 1ns/1ps
module srfc_crc_lrc (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        clr_i,
  input  wire        step_i,
  input  wire [7:0]  byte_i,
  output reg  [15:0] crc_o,
  output wire [7:0]  lrc_o
);
`include "srfc_defs.vh"
  reg  [7:0]  sum;
  reg  [15:0] next_crc;
  integer     k;
  //////////////////////////////////////////////////////////////////////
  // One byte through the shift loop, fully unrolled by the loop
  always @* begin
    next_crc = crc_o ^ {8'h00, byte_i};
    for (k = 0; k < 8; k = k + 1) begin
      if (next_crc[0]) begin
        next_crc = (next_crc >> 1) ^ `SRFC_CRC_POLY;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Accumulators; a clear beats a byte in the same cycle (never both)
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_o <= `SRFC_CRC_INIT;
      sum   <= 8'h00;
    end else if (clr_i) begin
      crc_o <= `SRFC_CRC_INIT;
      sum   <= 8'h00;
    end else if (step_i) begin
      crc_o <= next_crc;
      sum   <= sum + byte_i;
    end
  end
  // Two's complement of the carry-free sum
  assign lrc_o = ~sum + 8'h01;
endmodule // srfc_crc_lrc

// ===== sim/srfc_host_asserts.sv
// Checker: framing and handshake assertions on the host ports.
// Assumes a bind onto srfc_host and the constants of srfc_defs.vh.
`timescale 1ns/1ps
`include "srfc_defs.vh"
module srfc_host_asserts #(
  parameter int SIL_CYC = `SRFC_SIL_CYC // Line silence in cycles
) (
  input wire       core_clk_i,
  input wire       rst_i,
  input wire       ascii_mode_i,
  input wire       tx_ready_i,
  input wire       tx_valid_o,
  input wire [7:0] tx_byte_o,
  input wire       rsp_valid_o,
  input wire       busy_o,
  input wire       done_o,
  input wire       ok_o,
  input wire       timeout_o
);
  localparam int SIL_MIN = SIL_CYC - 4;
  wire       acc = tx_valid_o & tx_ready_i;
  wire [7:0] b   = tx_byte_o;
  wire       prn = (b >= 8'h30 && b <= 8'h39) || (b >= 8'h41 && b <= 8'h46)
                || (b >= 8'h61 && b <= 8'h66) || b == 8'h3a || b == 8'h0d
                || b == 8'h0a;
  reg        first;
  reg [7:0]  last;
  reg [31:0] cnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////
  // First byte of a request, previous byte, cycles since busy rose
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first <= 1'b1;
      last  <= 8'h00;
      cnt   <= 32'h0;
    end else begin
      first <= !busy_o | (first & !acc);
      last  <= acc ? b : last;
      cnt   <= busy_o ? cnt + 32'h1 : 32'h0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o)) else $error("tx byte dropped");
  chk_colon_first: assert property (acc && first && ascii_mode_i |->
    b == 8'h3a) else $error("ascii request not opened by colon");
  chk_lf_after_cr: assert property (
    acc && ascii_mode_i && b == 8'h0a |-> last == 8'h0d)
    else $error("line feed without carriage return");
  chk_ascii_print: assert property (
    tx_valid_o && ascii_mode_i |-> prn)
    else $error("ascii byte not printable hex");
  chk_rtu_silence: assert property (acc && first && !ascii_mode_i |->
    cnt >= SIL_MIN) else $error("rtu frame sent without silence");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_done_flags: assert property (done_o |-> !(ok_o && timeout_o))
    else $error("ok and timeout together");
  chk_only_answer: assert property (
    tx_valid_o || rsp_valid_o |-> busy_o)
    else $error("traffic outside a request");
  cover property (done_o && ok_o);
  cover property (done_o && timeout_o);
  cover property (done_o && !ok_o);
  cover property (acc && first && !ascii_mode_i);
endmodule // srfc_host_asserts

bind srfc_host srfc_host_asserts #(.SIL_CYC(SIL)) chk_u (.core_clk_i,
  .rst_i, .ascii_mode_i, .tx_ready_i, .tx_valid_o, .tx_byte_o,
  .rsp_valid_o, .busy_o, .done_o, .ok_o, .timeout_o);

// ===== sim/srfc_dev_model.sv
// Device model: answers host requests in ASCII or RTU framing.
// Assumes the host's byte UART ports on the same clock.
`timescale 1ns/1ps
module srfc_dev_model #(
  parameter [7:0] ADDR = 8'h01, // Station address
  parameter       SIL  = 1000   // Silence in cycles
) (
  input  wire       core_clk_i,
  input  wire       ascii_i,
  input  wire       bad_i,
  input  wire       tx_valid_i,
  input  wire [7:0] tx_byte_i,
  output reg        tx_ready_o,
  output reg        rx_strobe_o,
  output reg  [7:0] rx_byte_o
);
  reg [7:0]  c [0:63];
  reg [7:0]  rep [0:15];
  reg [7:0]  s;
  reg [15:0] r;
  reg        fin, seen, req_ok;
  integer    n, i, idle, rep_n;
  function [15:0] crc(input [15:0] r0, input [7:0] d);
    integer j;
    begin
      crc = r0 ^ {8'h00, d};
      for (j = 0; j < 8; j = j + 1)
        crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
    end
  endfunction
  function [7:0] hc(input [3:0] h); // High nibble first by caller
    hc = h < 4'ha ? {4'h3, h} : {4'h4, h - 4'h9};
  endfunction
  // Byte is held around the strobe, then inverted as the line lets go
  task put(input [7:0] v);
    begin
      rx_byte_o <= v;
      repeat (2) @(posedge core_clk_i);
      rx_strobe_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rx_strobe_o <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rx_byte_o <= ~v;
      repeat (3) @(posedge core_clk_i);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Only answers; collects a request while stalling every other cycle
  initial begin
    {tx_ready_o, rx_strobe_o, rx_byte_o, req_ok, rep_n} = 0;
    forever begin
      {n, idle, fin, seen} = 0;
      while (!fin) begin
        @(posedge core_clk_i);
        idle = idle + 1;
        if (tx_valid_i && tx_ready_o) begin
          idle = 0; // Restarts per character
          seen = seen | (ascii_i && tx_byte_i == 8'h3a);
          n = (ascii_i && tx_byte_i == 8'h3a) ? 0 : n + 1;
          c[n > 0 ? n - 1 : 0] = tx_byte_i;
          fin = seen && n > 1 && c[n-1] == 8'h0a && c[n-2] == 8'h0d;
        end
        fin = fin | (!ascii_i && n > 0 && idle >= SIL);
        tx_ready_o <= ~tx_ready_o;
      end
      tx_ready_o <= 1'b0;
      n = ascii_i ? (n - 2) / 2 : n;
      {s, r} = {8'h00, 16'hffff};
      for (i = 0; i < n; i = i + 1) begin
        if (ascii_i)
          c[i] = {c[2*i][3:0] + (c[2*i][6] ? 4'h9 : 4'h0),
                  c[2*i+1][3:0] + (c[2*i+1][6] ? 4'h9 : 4'h0)};
        s = s + c[i];
        r = crc(r, c[i]);
      end
      req_ok = (ascii_i ? s == 8'h00 : r == 16'h0000) && n >= 4
        && c[0] == ADDR && (c[1] == 8'h04 || c[1] == 8'h10);
      if (req_ok) begin
        // Write echo: address, function, start, count, then check
        {s, r} = {8'h00, 16'hffff};
        for (i = 0; i < 6; i = i + 1) begin
          rep[i] = c[i];
          s = s + c[i];
          r = crc(r, c[i]);
        end
        rep[6] = (ascii_i ? 8'h00 - s : r[7:0]) ^ {7'h00, bad_i};
        rep[7] = r[15:8];
        rep_n = ascii_i ? 7 : 8;
        repeat (SIL) @(posedge core_clk_i);
        if (ascii_i) put(8'h3a);
        for (i = 0; i < rep_n; i = i + 1)
          if (ascii_i) begin
            put(hc(rep[i][7:4]));
            put(hc(rep[i][3:0]));
          end else
            put(rep[i]);
        if (ascii_i) put(8'h0d);
        if (ascii_i) put(8'h0a);
      end
    end
  end
endmodule // srfc_dev_model

// ===== sim/tb.sv
// Bench: host frame controller against the device model.
// Assumes rtl/srfc_host.v, srfc_defs.vh and the model in sim.
`timescale 1ns/1ps
`include "srfc_defs.vh"
module tb;
  reg        core_clk_i, rst_i, ascii_mode_i, start_i, bad;
  wire       tx_ready_i, tx_valid_o, rx_strobe_i, busy_o, rsp_valid_o;
  wire       done_o, ok_o, timeout_o;
  wire [7:0] req_idx_o, tx_byte_o, rx_byte_i, rsp_byte_o;
  reg  [7:0] rq [0:15];
  reg  [7:0] rsp [0:31];
  integer    rn, miscompares, n_compared, cyc, k;
  // Short silence, wait and gap keep the whole run to a few 10k cycles
  localparam SIM_SIL = 200;
  localparam SIM_TMO = 5000;
  localparam SIM_GAP = 1000;
  localparam LIMIT   = 30000;  // Five requests need about 13k cycles
  wire [7:0] req_byte_i = rq[req_idx_o[3:0]];
  srfc_host #(.SIL(SIM_SIL), .TMO(SIM_TMO), .GAP(SIM_GAP)) uut (
    .core_clk_i, .rst_i, .ascii_mode_i, .start_i,
    .req_len_i(8'h09), .req_byte_i, .req_idx_o, .tx_ready_i, .tx_valid_o,
    .tx_byte_o, .rx_strobe_i, .rx_byte_i, .busy_o, .rsp_valid_o,
    .rsp_byte_o, .done_o, .ok_o, .timeout_o);
  srfc_dev_model #(.SIL(SIM_SIL)) dev (.core_clk_i,
    .ascii_i(ascii_mode_i), .bad_i(bad), .tx_valid_i(tx_valid_o),
    .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i),
    .rx_strobe_o(rx_strobe_i), .rx_byte_o(rx_byte_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Reply capture and watchdog; a request costs about two gaps, about six when it times out
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (rsp_valid_o === 1'b1 && rn < 32) rsp[rn] = rsp_byte_o;
    if (rsp_valid_o === 1'b1) rn = rn + 1;
    if (cyc == LIMIT) miscompares = miscompares + 1;
    if (cyc == LIMIT) summarize;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s exp %h seen %h", what, exp, got);
      end
    end
  endtask
  // One request; start is held until busy shows it was taken. A quiet
  // request is one the device must ignore, so the host has to time out.
  task run(input m, input b, input quiet);
    begin
      rn = 0;
      ascii_mode_i <= m;
      bad <= b;
      start_i <= 1'b1;
      @(posedge core_clk_i);
      while (busy_o !== 1'b1) @(posedge core_clk_i);
      start_i <= 1'b0;
      while (busy_o === 1'b1) @(posedge core_clk_i);
      chk("timeout", {7'h00, quiet}, {7'h00, timeout_o});
      chk("request", {7'h00, ~quiet}, {7'h00, dev.req_ok});
    end
  endtask
  task chk_reply;
    begin
      chk("count", dev.rep_n[7:0], rn[7:0]);
      for (k = 0; k < dev.rep_n; k = k + 1)
        chk("reply", k < 6 ? rq[k] : dev.rep[k], rsp[k]);
    end
  endtask
  task test_ascii_ok;
    begin
      run(1'b1, 1'b0, 1'b0);
      chk("ok", 8'h01, {7'h00, ok_o});
      chk_reply;
      $display("test ascii_ok done");
    end
  endtask
  task test_rtu_ok;
    begin
      run(1'b0, 1'b0, 1'b0);
      chk("ok", 8'h01, {7'h00, ok_o});
      chk_reply;
      $display("test rtu_ok done");
    end
  endtask
  task test_ascii_bad;
    begin
      run(1'b1, 1'b1, 1'b0);
      chk("ok", 8'h00, {7'h00, ok_o});
      $display("test ascii_bad done");
    end
  endtask
  task test_rtu_bad;
    begin
      run(1'b0, 1'b1, 1'b0);
      chk("ok", 8'h00, {7'h00, ok_o});
      $display("test rtu_bad done");
    end
  endtask
  // Another station's address: no reply, so the reply wait runs out
  task test_other_addr;
    begin
      rq[0] <= 8'h02;
      run(1'b1, 1'b0, 1'b1);
      chk("ok", 8'h00, {7'h00, ok_o});
      chk("count", 8'h00, rn[7:0]);
      rq[0] <= `SRFC_ADDR_DEF;
      $display("test other_addr done");
    end
  endtask
  task summarize;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    {rst_i, ascii_mode_i, start_i, bad} = 4'b1100;
    {rn, miscompares, n_compared, cyc} = 0;
    {rq[0], rq[1], rq[2], rq[3], rq[4], rq[5], rq[6], rq[7], rq[8]} =
      72'h01_10_00_40_00_01_02_00_ea;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    test_ascii_ok;
    test_rtu_ok;
    test_ascii_bad;
    test_rtu_bad;
    test_other_addr;
    summarize;
  end
endmodule // tb
